// >>> common/combo_wake_pkg.sv
package combo_wake_pkg;

  // ---------------------------------------------------------------
  // combination slot registers
  // ---------------------------------------------------------------
  localparam int unsigned SLOT_COUNT       = 3;
  localparam logic [7:0]  SLOT_BASE_ADDR   = 8'h65;
  localparam logic [7:0]  SLOT_RESET_VALUE = 8'hF8;
  localparam logic [1:0]  SLOT_ACTIVE_USED = 2'h0;
  localparam int unsigned SLOT_ACTIVE_MSB  = 7;
  localparam int unsigned SLOT_ACTIVE_LSB  = 6;
  localparam int unsigned SLOT_ROW_MSB     = 5;
  localparam int unsigned SLOT_ROW_LSB     = 3;
  localparam int unsigned SLOT_COL_MSB     = 2;
  localparam int unsigned SLOT_COL_LSB     = 0;

  // ---------------------------------------------------------------
  // scanner report
  // ---------------------------------------------------------------
  localparam int unsigned KEY_REPORTS      = 3;
  localparam int unsigned RESET_SYNC_DEPTH = 2;

  typedef struct packed {
    logic       down;
    logic [2:0] row;
    logic [2:0] col;
  } key_report_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } slot_access_s;

endpackage : combo_wake_pkg

// >>> logic/keypad_combo_wake_detector.sv
`timescale 1ns/100ps

module keypad_combo_wake_detector
  import combo_wake_pkg::*;
#(
  parameter int unsigned REPORTS = KEY_REPORTS
) (
  // clock and reset sources
  input  wire logic                        clock,
  input  wire logic                        nrst,
  input  wire logic                        power_on_ok,
  input  wire logic                        low_supply_lockout,
  // slot register access
  input  wire slot_access_s                slot_access,
  output logic [7:0]                       slot_rdata,
  output logic                             slot_rvalid,
  // keypad scanner report
  input  wire key_report_s [REPORTS-1:0]   key_report,
  input  wire logic                        scanner_asleep,
  input  wire logic                        combo_wake_enable,
  // wake and interrupt
  output logic                             wake_req,
  output logic                             combo_irq
);

  // -------------------------------------------------------------
  // reset combination and synchroniser
  // -------------------------------------------------------------
  logic                        rst_raw_n;
  logic [RESET_SYNC_DEPTH-1:0] rst_sync_q;
  logic                        rst_n;
  logic                        por_hold;
  logic                        pin_hold;
  logic                        lockout_hold;

  // power-on, external pin and lockout each force reset on their own
  assign por_hold     = ~power_on_ok;
  assign pin_hold     = ~nrst;
  assign lockout_hold = low_supply_lockout;
  assign rst_raw_n    = ~(por_hold | pin_hold | lockout_hold);

  always_ff @(posedge clock or negedge rst_raw_n) begin
    if (!rst_raw_n) begin
      rst_sync_q <= '0;
    end else begin
      rst_sync_q <= {rst_sync_q[RESET_SYNC_DEPTH-2:0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[RESET_SYNC_DEPTH-1];

  // -------------------------------------------------------------
  // combination slot registers
  // -------------------------------------------------------------
  logic [SLOT_COUNT-1:0][7:0] slot_q;

  function automatic logic slot_hit(input logic [7:0] addr, input int unsigned idx);
    slot_hit = (addr == SLOT_BASE_ADDR + 8'(idx));
  endfunction : slot_hit

  function automatic logic slot_used(input logic [7:0] slot);
    slot_used = (slot[SLOT_ACTIVE_MSB:SLOT_ACTIVE_LSB] == SLOT_ACTIVE_USED);
  endfunction : slot_used

  function automatic logic [2:0] slot_row(input logic [7:0] slot);
    slot_row = slot[SLOT_ROW_MSB:SLOT_ROW_LSB];
  endfunction : slot_row

  function automatic logic [2:0] slot_col(input logic [7:0] slot);
    slot_col = slot[SLOT_COL_MSB:SLOT_COL_LSB];
  endfunction : slot_col

  // a report position carries a slot key only while that key is down
  function automatic logic key_on_slot(input key_report_s rep, input logic [7:0] slot);
    key_on_slot = rep.down && rep.row == slot_row(slot) && rep.col == slot_col(slot);
  endfunction : key_on_slot

  logic [SLOT_COUNT-1:0] slot_we;

  // one enable per slot, so a strobe can only touch the slot it addresses
  always_comb begin
    slot_we = '0;
    for (int unsigned i = 0; i < SLOT_COUNT; i++) begin
      slot_we[i] = slot_access.wr && slot_hit(slot_access.addr, i);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      slot_q <= {SLOT_COUNT{SLOT_RESET_VALUE}};
    end else begin
      for (int unsigned i = 0; i < SLOT_COUNT; i++) begin
        if (slot_we[i]) begin
          slot_q[i] <= slot_access.wdata;
        end
      end
    end
  end

  // read data: unmapped addresses read as zero
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic       rvalid_q;

  always_comb begin
    rdata_d = 8'h00;
    for (int unsigned i = 0; i < SLOT_COUNT; i++) begin
      if (slot_hit(slot_access.addr, i)) begin
        rdata_d = slot_q[i];
      end
    end
  end

  // read strobe answered one cycle later
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= slot_access.rd;
    end
  end

  // read data holds until the next read
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (slot_access.rd) begin
      rdata_q <= rdata_d;
    end
  end

  assign slot_rdata  = rdata_q;
  assign slot_rvalid = rvalid_q;

  // -------------------------------------------------------------
  // combination match
  // -------------------------------------------------------------
  logic [SLOT_COUNT-1:0] slot_seen;
  logic [REPORTS-1:0]    report_known;
  logic                  any_used;
  logic                  all_seen;
  logic                  stray_key;
  logic                  match;

  // any report position may carry the key, so press order is irrelevant
  always_comb begin
    slot_seen    = '0;
    report_known = '0;
    for (int unsigned s = 0; s < SLOT_COUNT; s++) begin
      for (int unsigned k = 0; k < REPORTS; k++) begin
        if (slot_used(slot_q[s]) && key_on_slot(key_report[k], slot_q[s])) begin
          slot_seen[s]    = 1'b1;
          report_known[k] = 1'b1;
        end
      end
    end
  end

  // every used slot must have its key down
  always_comb begin
    any_used = 1'b0;
    all_seen = 1'b1;
    for (int unsigned s = 0; s < SLOT_COUNT; s++) begin
      if (slot_used(slot_q[s])) begin
        any_used = 1'b1;
        if (!slot_seen[s]) begin
          all_seen = 1'b0;
        end
      end
    end
  end

  // a down key that no used slot names spoils the match
  always_comb begin
    stray_key = 1'b0;
    for (int unsigned k = 0; k < REPORTS; k++) begin
      if (key_report[k].down && !report_known[k]) begin
        stray_key = 1'b1;
      end
    end
  end

  // with no used slot the detector stays silent
  assign match = any_used && all_seen && !stray_key;

  // -------------------------------------------------------------
  // wake and interrupt
  // -------------------------------------------------------------
  logic irq_d;
  logic irq_q;
  logic wake_d;
  logic wake_q;

  assign irq_d  = match && combo_wake_enable;
  // wake only matters while the scanner sleeps
  assign wake_d = irq_d && scanner_asleep;

  // interrupt stands while the match holds and combo_wake_enable is set
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= wake_d;
    end
  end

  assign combo_irq = irq_q;
  assign wake_req  = wake_q;

endmodule : keypad_combo_wake_detector

// >>> verif/combo_wake_assertions.sv
`timescale 1ns/100ps
module combo_wake_assertions import combo_wake_pkg::*; #(parameter int unsigned REPORTS = 3) (
  input wire logic clock, nrst, power_on_ok, low_supply_lockout,
  input wire slot_access_s slot_access,
  input wire logic [7:0] slot_rdata,
  input wire logic slot_rvalid, scanner_asleep, combo_wake_enable, wake_req, combo_irq,
  input wire key_report_s [REPORTS-1:0] key_report);
  logic rst_n, used, hit, stray, in_set, match;
  logic [7:0] ofs, rd_exp, slot_q [3];
  assign rst_n = nrst & power_on_ok & ~low_supply_lockout;
  assign ofs = slot_access.addr - SLOT_BASE_ADDR;
  assign rd_exp = ofs < 8'h03 ? slot_q[ofs[1:0]] : 8'h00;
  // mirror of the slots, reset by every source
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n) slot_q <= '{default: SLOT_RESET_VALUE};
    else if (slot_access.wr && ofs < 8'h03) slot_q[ofs[1:0]] <= slot_access.wdata;
  function automatic logic down_at(logic [5:0] k);
    down_at = 1'b0;
    for (int j = 0; j < REPORTS; j++) down_at |= key_report[j].down && key_report[j][5:0] == k;
  endfunction : down_at
  always_comb begin
    used = 1'b0; hit = 1'b1; stray = 1'b0; in_set = 1'b0;
    for (int i = 0; i < 3; i++) if (slot_q[i][7:6] == SLOT_ACTIVE_USED) begin
      used = 1'b1; hit &= down_at(slot_q[i][5:0]);
    end
    for (int j = 0; j < REPORTS; j++) begin
      in_set = 1'b0;
      for (int i = 0; i < 3; i++)
        in_set |= slot_q[i][7:6] == SLOT_ACTIVE_USED && slot_q[i][5:0] == key_report[j][5:0];
      stray |= key_report[j].down && !in_set;
    end
  end
  assign match = used & hit & ~stray & combo_wake_enable;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence read_req; slot_access.rd; endsequence
  sequence read_ans; slot_rvalid && slot_rdata == $past(rd_exp); endsequence
  read_answer_a: assert property (read_req |=> read_ans) else $error("bad slot read");
  rvalid_pulse_a: assert property (!slot_access.rd |=> !slot_rvalid) else $error("extra rvalid");
  irq_on_match_a: assert property (match |=> combo_irq) else $error("irq missing");
  irq_drop_a: assert property (!match |=> !combo_irq) else $error("irq unexpected");
  wake_on_a: assert property (match && scanner_asleep |=> wake_req) else $error("no wake");
  wake_drop_a: assert property (!(match && scanner_asleep) |=> !wake_req) else $error("bad wake");
  no_slot_a: assert property (!used |=> !combo_irq && !wake_req) else $error("unused fired");
  reset_quiet_a: assert property (@(posedge clock) disable iff (1'b0)
    !rst_n |-> !combo_irq && !wake_req && !slot_rvalid) else $error("active in reset");
endmodule : combo_wake_assertions
bind keypad_combo_wake_detector combo_wake_assertions #(.REPORTS(REPORTS)) chk (.clock, .nrst,
  .power_on_ok, .low_supply_lockout, .slot_access, .slot_rdata, .slot_rvalid, .scanner_asleep,
  .combo_wake_enable, .wake_req, .combo_irq, .key_report);

// >>> verif/key_matrix_model.sv
`timescale 1ns/100ps
module key_matrix_model import combo_wake_pkg::*; (
  input wire logic clock,
  input wire key_report_s [2:0] held,
  output key_report_s [2:0] key_report);
  logic [2:0] spin_q = 3'h0;
  // released positions show key-up with coordinates that change every cycle
  always @(posedge clock) begin
    spin_q <= spin_q + 3'h1;
    for (int i = 0; i < 3; i++)
      key_report[i] <= held[i].down ? held[i] : {1'b0, held[i][5:0] ^ {spin_q, spin_q}};
  end
endmodule : key_matrix_model

// >>> verif/keypad_combo_wake_detector_test.sv
`timescale 1ns/100ps
module keypad_combo_wake_detector_test import combo_wake_pkg::*;;
  localparam key_report_s KA = 7'h55, KB = 7'h78, KC = 7'h5B, UP = 7'h00;
  logic clock = 0, nrst = 1, power_on_ok = 1, low_supply_lockout = 0;
  logic scanner_asleep = 0, combo_wake_enable = 0, slot_rvalid, wake_req, combo_irq;
  slot_access_s slot_access = '0;
  key_report_s [2:0] held = '0, key_report;
  logic [7:0] slot_rdata;
  int err_count = 0, checks = 0, cycles = 0;
  always #5 clock = ~clock;
  key_matrix_model pm (.clock, .held, .key_report);
  keypad_combo_wake_detector #(.REPORTS(3)) dut (.clock, .nrst, .power_on_ok, .low_supply_lockout,
    .slot_access, .slot_rdata, .slot_rvalid, .key_report, .scanner_asleep, .combo_wake_enable,
    .wake_req, .combo_irq);
  task test_done;
    if (err_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin err_count++; test_done; end
  end
  task cmp(logic [7:0] got, exp);
    checks++;
    if (got !== exp) begin
      err_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task acc(logic w, logic [7:0] a, d);
    @(posedge clock) slot_access <= {w, !w, a, d};
    @(posedge clock) slot_access <= '0;
    #1 cmp({7'h00, slot_rvalid}, {7'h00, !w});
  endtask : acc
  task key(key_report_s [2:0] k, logic en, sl);
    @(posedge clock) begin held <= k; combo_wake_enable <= en; scanner_asleep <= sl; end
    repeat (3) @(posedge clock);
    #1;
  endtask : key
  task outs(logic w, i); cmp({6'h00, wake_req, combo_irq}, {6'h00, w, i}); endtask : outs
  task s_regs;
    for (int i = 0; i < 3; i++) begin
      acc(0, SLOT_BASE_ADDR + i[7:0], 8'h00); cmp(slot_rdata, SLOT_RESET_VALUE);
    end
    acc(1, 8'h66, 8'h5A); acc(0, 8'h66, 8'h00); cmp(slot_rdata, 8'h5A);
    acc(1, 8'h68, 8'h11); acc(0, 8'h68, 8'h00); cmp(slot_rdata, 8'h00);
  endtask : s_regs
  task s_match;
    acc(1, 8'h65, 8'h15); acc(1, 8'h66, 8'h38); acc(1, 8'h67, SLOT_RESET_VALUE);
    key({UP, KB, KA}, 1, 1); outs(1, 1);
    key({KA, UP, KB}, 1, 0); outs(0, 1);
    key({KC, KA, KB}, 1, 1); outs(0, 0);
    key({UP, UP, KB}, 1, 1); outs(0, 0);
    key({UP, KA, KB}, 0, 1); outs(0, 0);
    acc(1, 8'h67, 8'h9B); key({UP, KA, KB}, 1, 1); outs(1, 1);
    acc(1, 8'h67, 8'h1B); key({KC, KA, KB}, 1, 1); outs(1, 1);
    for (int i = 0; i < 3; i++) acc(1, SLOT_BASE_ADDR + i[7:0], SLOT_RESET_VALUE);
    key({KC, KA, KB}, 1, 1); outs(0, 0);
  endtask : s_match
  task s_resets;
    acc(1, 8'h65, 8'h15); key({UP, UP, KA}, 1, 1); outs(1, 1);
    for (int k = 0; k < 3; k++) begin
      @(posedge clock) begin nrst <= k != 0; power_on_ok <= k != 1; low_supply_lockout <= k == 2; end
      @(posedge clock); #1 outs(0, 0);
      @(posedge clock) begin nrst <= 1; power_on_ok <= 1; low_supply_lockout <= 0; end
      repeat (3) @(posedge clock);
      acc(0, 8'h65, 8'h00); cmp(slot_rdata, SLOT_RESET_VALUE);
      acc(1, 8'h65, 8'h15);
    end
  endtask : s_resets
  initial begin
    @(posedge clock) nrst <= 1'b0;
    repeat (5) @(posedge clock);
    nrst <= 1;
    repeat (3) @(posedge clock);
    s_regs; s_match; s_resets;
    test_done;
  end
endmodule : keypad_combo_wake_detector_test
